// ---- logic/adcr_regs.svh ----
// Register offsets, bit positions and reset values of the acquisition
// control register block. Assumes 16-bit registers at byte offsets.
`ifndef ADCR_REGS_SVH
`define ADCR_REGS_SVH

// ----------------------------------------------------------------
// Offsets
// ----------------------------------------------------------------
`define ADCR_ADDR_W 4
`define ADCR_OFS_CTRL 4'h6
`define ADCR_OFS_IRQ 4'h8

// ----------------------------------------------------------------
// Control/status word fields
// ----------------------------------------------------------------
`define ADCR_MODE_MSB 2
`define ADCR_MODE_LSB 0
`define ADCR_CLK_BIT 3
`define ADCR_TRSRC_BIT 4
`define ADCR_EDGE_BIT 6
`define ADCR_CAL_BIT 7
`define ADCR_TCF_BIT 14
`define ADCR_TRGF_BIT 15

// ----------------------------------------------------------------
// Interrupt/FIFO word fields
// ----------------------------------------------------------------
`define ADCR_INTF_BIT 0
`define ADCR_AI_EMPTY_BIT 8
`define ADCR_AI_HALF_BIT 9
`define ADCR_AI_FULL_BIT 10
`define ADCR_AI_CLR_BIT 11
`define ADCR_AO_EMPTY_BIT 12
`define ADCR_AO_HALF_BIT 13
`define ADCR_AO_FULL_BIT 14
`define ADCR_AO_CLR_BIT 15
`define ADCR_BE_LOW 0
`define ADCR_BE_HIGH 1

// ----------------------------------------------------------------
// Sample word and reset values
// ----------------------------------------------------------------
`define ADCR_TAG_BIT 15
`define ADCR_WORD_ZERO 16'h0000
`define ADCR_MODE_RESET 3'h0
`define ADCR_BIT_RESET 1'b0

`endif

// ---- logic/adcr_pkg.sv ----
// Types shared by the acquisition control register block.
// Assumes adcr_regs.svh for field positions.
package adcr_pkg;

    // Acquisition modes as encoded in the mode field
    typedef enum logic [2:0] {
        ADCR_MODE_SINGLE = 3'h0,
        ADCR_MODE_PACER = 3'h1,
        ADCR_MODE_POST = 3'h2,
        ADCR_MODE_DELAY = 3'h3,
        ADCR_MODE_ABOUT = 3'h4
    } adcr_mode_e;

    // One register access from the host side
    typedef struct packed {
        logic rd;
        logic wr;
        logic [3:0] addr;
        logic [1:0] be;
        logic [15:0] wdata;
    } adcr_bus_req_s;

    // Level flags of one FIFO
    typedef struct packed {
        logic empty;
        logic half;
        logic full;
    } adcr_fifo_flags_s;

endpackage

// ---- logic/adcr_pin_edge.sv ----
// Two-stage synchroniser with rising and falling edge pulses.
// Assumes an asynchronous pin and one system clock.
`timescale 1ns/100ps
`default_nettype none
module adcr_pin_edge
    import adcr_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic reset,
    // Pin and edges
    input wire logic pin,
    output logic rise,
    output logic fall
);

    typedef struct packed {
        logic meta;
        logic sync;
        logic last;
    } adcr_edge_s;

    adcr_edge_s st;
    adcr_edge_s next_st;

    // Only the second stage and its delayed copy feed the edge compare
    always_comb begin
        next_st = st;
        next_st.meta = pin;
        next_st.sync = st.meta;
        next_st.last = st.sync;
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign rise = st.sync & ~st.last;
    assign fall = ~st.sync & st.last;

endmodule
`default_nettype wire

// ---- logic/adcr_sticky_flag.sv ----
// Sticky event flag that software may force set or clear.
// Assumes set and write strobes come from the same clock.
`timescale 1ns/100ps
`default_nettype none
module adcr_sticky_flag
    import adcr_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic reset,
    // Sources
    input wire logic hw_set,
    input wire logic sw_write,
    input wire logic sw_value,
    // Results
    output logic flag,
    output logic event_pulse
);

    typedef struct packed {
        logic flag;
    } adcr_flag_s;

    adcr_flag_s st;
    adcr_flag_s next_st;

    // Hardware set wins over a software clear in the same cycle
    always_comb begin
        next_st = st;
        if (sw_write) begin
            next_st.flag = sw_value;
        end
        if (hw_set) begin
            next_st.flag = 1'b1;
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign flag = st.flag;
    // A software write of one acts like the real event
    assign event_pulse = hw_set | (sw_write & sw_value);

endmodule
`default_nettype wire

// ---- logic/adcr_top.sv ----
// Acquisition control/status and interrupt/FIFO clear register block.
// Assumes a 16-bit host register port with byte enables on the same
// clock, and FIFO flags and interrupt level from logic on that clock.
//
// Functional notes
// - Mode field bits 2..0: single, pacer, post, delay, about trigger.
// - Clock source bit picks internal tick or external sample clock pin.
// - Trigger source bit picks digital pin or analog threshold trigger.
// - Edge bit selects rising edge at 0, falling edge at 1.
// - Calibration bit 7 reroutes inputs 0, 2, 4, 6 for self test.
// - Terminal count flag bit 14 sets when DMA count ends.
// - Writing one to terminal count flag acts as real terminal count.
// - Trigger flag bit 15 sets on a conversion trigger event.
// - Writing one to trigger flag acts as a real trigger.
// - Any write to low byte at offset 8 clears the interrupt.
// - Writing zero to bit 15 at offset 8 empties output FIFO.
// - Offset 8 reads interrupt flag and both FIFO level flags.
// - Stored sample bit 15 tells whether it came after the trigger.
`include "adcr_regs.svh"
`timescale 1ns/100ps
`default_nettype none
module adcr_top
    import adcr_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic reset,
    // Host register port
    input wire adcr_bus_req_s bus_req,
    output logic [15:0] bus_rdata,
    output logic bus_rvalid,
    // Sample timing
    input wire logic internal_sample_tick,
    input wire logic ext_sample_clock_pin,
    output logic sample_tick,
    // Trigger inputs and events
    input wire logic digital_trigger_pin,
    input wire logic analog_trigger_pin,
    output logic trigger_event,
    // DMA terminal count
    input wire logic dma_terminal_count,
    output logic terminal_event,
    // Mode and calibration routing
    output adcr_mode_e acq_mode_field,
    output logic trigger_mode_active,
    output logic calibration_routing_bit,
    // Interrupt and FIFO service
    input wire logic irq_pending,
    output logic irq_clear,
    input wire adcr_fifo_flags_s in_fifo_flags,
    input wire adcr_fifo_flags_s out_fifo_flags,
    output logic input_fifo_clear,
    output logic output_fifo_clear,
    // Conversion words
    input wire logic sample_valid,
    input wire logic [14:0] sample_data,
    output logic [15:0] stored_word,
    output logic stored_valid
);

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    // Clear strobes and read data are registered so those outputs never glitch
    typedef struct packed {
        adcr_mode_e mode;
        logic clk_src;
        logic trg_src;
        logic trg_edge;
        logic cal;
        logic [15:0] rdata;
        logic rvalid;
        logic [15:0] word;
        logic word_valid;
        logic irq_clr;
        logic in_clr;
        logic out_clr;
    } adcr_state_s;

    adcr_state_s st;
    adcr_state_s next_st;

    // ----------------------------------------------------------------
    // Decode of the host access
    // ----------------------------------------------------------------
    logic hit_ctrl;
    logic hit_irq;
    logic wr_ctrl_lo;
    logic wr_ctrl_hi;
    logic wr_irq_lo;
    logic wr_irq_hi;

    // Byte enables gate each half so a byte write leaves the other alone
    assign hit_ctrl = (bus_req.addr == `ADCR_OFS_CTRL);
    assign hit_irq = (bus_req.addr == `ADCR_OFS_IRQ);
    assign wr_ctrl_lo = bus_req.wr & hit_ctrl & bus_req.be[`ADCR_BE_LOW];
    assign wr_ctrl_hi = bus_req.wr & hit_ctrl & bus_req.be[`ADCR_BE_HIGH];
    assign wr_irq_lo = bus_req.wr & hit_irq & bus_req.be[`ADCR_BE_LOW];
    assign wr_irq_hi = bus_req.wr & hit_irq & bus_req.be[`ADCR_BE_HIGH];

    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    logic ext_clk_rise;
    logic dig_rise;
    logic dig_fall;
    logic ana_rise;
    logic ana_fall;

    // Edges appear one to two cycles after the pin moves, so a pin
    // pulse shorter than one clock period may be missed. A pin held
    // high through reset gives one rising edge shortly after release.
    // External sample clock, only its rising edge is used
    adcr_pin_edge u_ext_clk (
        .clock(clock),
        .reset(reset),
        .pin(ext_sample_clock_pin),
        .rise(ext_clk_rise),
        .fall()
    );

    // Digital trigger pin, both edges kept for the edge select
    adcr_pin_edge u_dig_trg (
        .clock(clock),
        .reset(reset),
        .pin(digital_trigger_pin),
        .rise(dig_rise),
        .fall(dig_fall)
    );

    // Analog threshold trigger, handled like a pin
    adcr_pin_edge u_analog_trigger_pin (
        .clock(clock),
        .reset(reset),
        .pin(analog_trigger_pin),
        .rise(ana_rise),
        .fall(ana_fall)
    );

    // ----------------------------------------------------------------
    // Timing and trigger selection
    // ----------------------------------------------------------------
    logic sel_rise;
    logic sel_fall;
    logic hw_trigger;

    // Selection is combinational, so a source change costs at most one edge
    // External clock counts on its rising edge only
    assign sample_tick = st.clk_src ? ext_clk_rise : internal_sample_tick;
    assign sel_rise = st.trg_src ? ana_rise : dig_rise;
    assign sel_fall = st.trg_src ? ana_fall : dig_fall;
    assign hw_trigger = st.trg_edge ? sel_fall : sel_rise;

    // ----------------------------------------------------------------
    // Sticky event flags
    // ----------------------------------------------------------------
    logic trg_flag;
    logic tc_flag;

    // Both flags share the high byte write; a write to the low half
    // alone leaves them untouched
    // Trigger flag: real edge or forced by software
    adcr_sticky_flag u_trg_flag (
        .clock(clock),
        .reset(reset),
        .hw_set(hw_trigger),
        .sw_write(wr_ctrl_hi),
        .sw_value(bus_req.wdata[`ADCR_TRGF_BIT]),
        .flag(trg_flag),
        .event_pulse(trigger_event)
    );

    // Terminal count flag: DMA counter end or forced by software
    adcr_sticky_flag u_tc_flag (
        .clock(clock),
        .reset(reset),
        .hw_set(dma_terminal_count),
        .sw_write(wr_ctrl_hi),
        .sw_value(bus_req.wdata[`ADCR_TCF_BIT]),
        .flag(tc_flag),
        .event_pulse(terminal_event)
    );

    // ----------------------------------------------------------------
    // Read words
    // ----------------------------------------------------------------
    logic [15:0] ctrl_word;
    logic [15:0] irq_word;

    // Calibration bit is write only and reads as zero
    always_comb begin
        ctrl_word = `ADCR_WORD_ZERO;
        ctrl_word[`ADCR_MODE_MSB:`ADCR_MODE_LSB] = st.mode;
        ctrl_word[`ADCR_CLK_BIT] = st.clk_src;
        ctrl_word[`ADCR_TRSRC_BIT] = st.trg_src;
        ctrl_word[`ADCR_EDGE_BIT] = st.trg_edge;
        ctrl_word[`ADCR_TCF_BIT] = tc_flag;
        ctrl_word[`ADCR_TRGF_BIT] = trg_flag;
    end

    // Interrupt pending and the six FIFO level flags
    // Levels pass as they stand; the read register captures them
    always_comb begin
        irq_word = `ADCR_WORD_ZERO;
        irq_word[`ADCR_INTF_BIT] = irq_pending;
        irq_word[`ADCR_AI_EMPTY_BIT] = in_fifo_flags.empty;
        irq_word[`ADCR_AI_HALF_BIT] = in_fifo_flags.half;
        irq_word[`ADCR_AI_FULL_BIT] = in_fifo_flags.full;
        irq_word[`ADCR_AO_EMPTY_BIT] = out_fifo_flags.empty;
        irq_word[`ADCR_AO_HALF_BIT] = out_fifo_flags.half;
        irq_word[`ADCR_AO_FULL_BIT] = out_fifo_flags.full;
    end

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        next_st = st;
        next_st.rvalid = bus_req.rd;
        next_st.irq_clr = 1'b0;
        next_st.in_clr = 1'b0;
        next_st.out_clr = 1'b0;
        next_st.word_valid = 1'b0;
        // Control fields live in the low byte
        if (wr_ctrl_lo) begin
            next_st.mode = adcr_mode_e'(bus_req.wdata[`ADCR_MODE_MSB:`ADCR_MODE_LSB]);
            next_st.clk_src = bus_req.wdata[`ADCR_CLK_BIT];
            next_st.trg_src = bus_req.wdata[`ADCR_TRSRC_BIT];
            next_st.trg_edge = bus_req.wdata[`ADCR_EDGE_BIT];
            next_st.cal = bus_req.wdata[`ADCR_CAL_BIT];
        end
        // Data written to the low byte does not matter
        if (wr_irq_lo) begin
            next_st.irq_clr = 1'b1;
        end
        // FIFO clears are active low bits in the high byte
        if (wr_irq_hi) begin
            next_st.in_clr = ~bus_req.wdata[`ADCR_AI_CLR_BIT];
            next_st.out_clr = ~bus_req.wdata[`ADCR_AO_CLR_BIT];
        end
        // Read data is captured only on a read and holds until the next
        // Unmapped reads answer zero rather than stale data
        if (bus_req.rd) begin
            if (hit_ctrl) begin
                next_st.rdata = ctrl_word;
            end else if (hit_irq) begin
                next_st.rdata = irq_word;
            end else begin
                next_st.rdata = `ADCR_WORD_ZERO;
            end
        end
        // Tag each sample with the trigger flag as it is stored
        if (sample_valid) begin
            next_st.word = {trg_flag, sample_data};
            next_st.word_valid = 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // State register
    // ----------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (reset) begin
            st.mode <= adcr_mode_e'(`ADCR_MODE_RESET);
            st.clk_src <= `ADCR_BIT_RESET;
            st.trg_src <= `ADCR_BIT_RESET;
            st.trg_edge <= `ADCR_BIT_RESET;
            st.cal <= `ADCR_BIT_RESET;
            st.rdata <= `ADCR_WORD_ZERO;
            st.rvalid <= 1'b0;
            st.word <= `ADCR_WORD_ZERO;
            st.word_valid <= 1'b0;
            st.irq_clr <= 1'b0;
            st.in_clr <= 1'b0;
            st.out_clr <= 1'b0;
        end else begin
            st <= next_st;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    // Trigger based modes are the ones that need the flags cleared first
    assign acq_mode_field = st.mode;
    assign trigger_mode_active = (st.mode == ADCR_MODE_POST) |
                                 (st.mode == ADCR_MODE_DELAY) |
                                 (st.mode == ADCR_MODE_ABOUT);
    assign calibration_routing_bit = st.cal;
    assign bus_rdata = st.rdata;
    assign bus_rvalid = st.rvalid;
    // Clear strobes last one cycle; the FIFO and interrupt logic act on them
    assign irq_clear = st.irq_clr;
    assign input_fifo_clear = st.in_clr;
    assign output_fifo_clear = st.out_clr;
    assign stored_word = st.word;
    assign stored_valid = st.word_valid;

endmodule
`default_nettype wire

// ---- testbench/adcr_checker_asserts.sv ----
// Assertion checker for the acquisition control register block.
// Assumes it is bound to adcr_top and sees only that module's ports.
`timescale 1ns/100ps
`default_nettype none
module adcr_checker
    import adcr_pkg::*;
(
    // Clock, reset and host port
    input wire logic clock, reset,
    input wire adcr_bus_req_s bus_req,
    input wire logic [15:0] bus_rdata,
    input wire logic bus_rvalid,
    // Timing, triggers and terminal count
    input wire logic internal_sample_tick, ext_sample_clock_pin, sample_tick,
    input wire logic digital_trigger_pin, analog_trigger_pin, trigger_event,
    input wire logic dma_terminal_count, terminal_event,
    // Mode, interrupt and FIFO service
    input wire adcr_mode_e acq_mode_field,
    input wire logic trigger_mode_active, calibration_routing_bit,
    input wire logic irq_pending, irq_clear, input_fifo_clear, output_fifo_clear,
    input wire adcr_fifo_flags_s in_fifo_flags, out_fifo_flags,
    // Conversion words
    input wire logic sample_valid, stored_valid,
    input wire logic [14:0] sample_data,
    input wire logic [15:0] stored_word
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);

    // ----------------
    // Decoded causes
    // ----------------
    logic wr6, wr8, rd6, hi6, irq_cause, in_cause, out_cause;
    logic [15:0] exp8;
    // Decoded once so each property names its cause plainly
    assign wr6 = bus_req.wr && bus_req.addr == 4'h6;
    assign wr8 = bus_req.wr && bus_req.addr == 4'h8;
    assign rd6 = bus_req.rd && bus_req.addr == 4'h6;
    assign hi6 = wr6 && bus_req.be[1];
    assign irq_cause = wr8 && bus_req.be[0];
    assign in_cause = wr8 && bus_req.be[1] && !bus_req.wdata[11];
    assign out_cause = wr8 && bus_req.be[1] && !bus_req.wdata[15];
    assign exp8 = {1'b0, out_fifo_flags.full, out_fifo_flags.half, out_fifo_flags.empty,
        1'b0, in_fifo_flags.full, in_fifo_flags.half, in_fifo_flags.empty, 7'h00, irq_pending};

    // ----------------
    // Properties
    // ----------------
    a_mode_written: assert property (wr6 && bus_req.be[0] |=>
        acq_mode_field == $past(bus_req.wdata[2:0])) else $error("mode field not written");
    a_mode_active: assert property (trigger_mode_active ==
        (acq_mode_field inside {3'h2, 3'h3, 3'h4})) else $error("trigger mode level wrong");
    a_cal_written: assert property (wr6 && bus_req.be[0] |=>
        calibration_routing_bit == $past(bus_req.wdata[7])) else $error("cal bit wrong");
    a_hw_terminal: assert property (dma_terminal_count |-> terminal_event)
        else $error("terminal count not passed on");
    a_sw_terminal: assert property (hi6 && bus_req.wdata[14] |-> terminal_event)
        else $error("forced terminal count missing");
    a_flag_visible: assert property ($past(trigger_event, 2) && !$past(hi6) && rd6
        |=> bus_rdata[15]) else $error("trigger flag not raised");
    a_sw_trigger: assert property (hi6 && bus_req.wdata[15] |-> trigger_event)
        else $error("forced trigger missing");
    a_irq_clear: assert property (irq_clear == $past(irq_cause))
        else $error("interrupt clear pulse wrong");
    a_in_clear: assert property (input_fifo_clear == $past(in_cause))
        else $error("input fifo clear pulse wrong");
    a_out_clear: assert property (output_fifo_clear == $past(out_cause))
        else $error("output fifo clear pulse wrong");
    a_status_word: assert property (bus_req.rd && bus_req.addr == 4'h8 |=>
        bus_rvalid && bus_rdata == $past(exp8)) else $error("status word wrong");
    a_ctrl_read: assert property (rd6 |=> bus_rvalid && !bus_rdata[7] &&
        bus_rdata[2:0] == $past(acq_mode_field)) else $error("control readback wrong");
    a_stored_word: assert property (sample_valid |=> stored_valid &&
        stored_word[14:0] == $past(sample_data)) else $error("stored word wrong");

    // Main scenarios reached
    c_trigger: cover property (trigger_event);
    c_in_clear: cover property (input_fifo_clear);
    c_tagged: cover property (stored_valid && stored_word[15]);
endmodule

bind adcr_top adcr_checker u_chk (.clock, .reset, .bus_req, .bus_rdata, .bus_rvalid,
    .internal_sample_tick, .ext_sample_clock_pin, .sample_tick, .digital_trigger_pin,
    .analog_trigger_pin, .trigger_event, .dma_terminal_count, .terminal_event,
    .acq_mode_field, .trigger_mode_active, .calibration_routing_bit, .irq_pending,
    .irq_clear, .input_fifo_clear, .output_fifo_clear, .in_fifo_flags, .out_fifo_flags,
    .sample_valid, .stored_valid, .sample_data, .stored_word);
`default_nettype wire

// ---- testbench/adc_control_irq_fifo_regs_tb.sv ----
// Self-checking bench for the acquisition control register block.
// Assumes adcr_top with a one-cycle read latency on its host port.
`timescale 1ns/100ps
`default_nettype none
module adc_control_irq_fifo_regs_tb
    import adcr_pkg::*;
;
    logic clock = 0, reset = 1;
    adcr_bus_req_s bus_req = '0;
    logic internal_sample_tick = 0, ext_sample_clock_pin = 0, dma_terminal_count = 0;
    logic digital_trigger_pin = 0, analog_trigger_pin = 0, irq_pending = 0, sample_valid = 0;
    logic [14:0] sample_data = '0;
    adcr_fifo_flags_s in_fifo_flags = '0, out_fifo_flags = '0;
    logic [15:0] bus_rdata, stored_word, d;
    logic bus_rvalid, sample_tick, trigger_event, terminal_event, trigger_mode_active;
    logic calibration_routing_bit, irq_clear, input_fifo_clear, output_fifo_clear;
    logic stored_valid, e, s;
    adcr_mode_e acq_mode_field;
    int num_errors = 0, total_checks = 0, cycles = 0;
    int cnt [6];
    int base [6];

    // 125 MHz clock
    always #4 clock = ~clock;

    adcr_top DUT (.clock, .reset, .bus_req, .bus_rdata, .bus_rvalid, .internal_sample_tick,
        .ext_sample_clock_pin, .sample_tick, .digital_trigger_pin, .analog_trigger_pin,
        .trigger_event, .dma_terminal_count, .terminal_event, .acq_mode_field,
        .trigger_mode_active, .calibration_routing_bit, .irq_pending, .irq_clear,
        .in_fifo_flags, .out_fifo_flags, .input_fifo_clear, .output_fifo_clear,
        .sample_valid, .sample_data, .stored_word, .stored_valid);

    // ----------------
    // Pulse counters and hang guard
    // ----------------
    // Counting pulses avoids guessing the exact synchroniser delay
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            num_errors++;
            conclude();
        end
        if (!reset) begin
            cnt[0] <= cnt[0] + int'(sample_tick);
            cnt[1] <= cnt[1] + int'(trigger_event);
            cnt[2] <= cnt[2] + int'(terminal_event);
            cnt[3] <= cnt[3] + int'(irq_clear);
            cnt[4] <= cnt[4] + int'(input_fifo_clear);
            cnt[5] <= cnt[5] + int'(output_fifo_clear);
        end
    end

    // ----------------
    // Tasks
    // ----------------
    task automatic conclude;
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask

    // Pulses seen on counter i since the last mark
    task automatic chkc(input int i, input int n);
        chk(16'(cnt[i] - base[i]), 16'(n));
    endtask

    task automatic mark;
        base = cnt;
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask

    // One write; an idle cycle follows so the strobe never re-rises at once
    task automatic wr(input logic [3:0] a, input logic [1:0] b, input logic [15:0] v);
        bus_req = {1'b0, 1'b1, a, b, v};
        tick(1);
        bus_req.wr = 0;
        tick(1);
    endtask

    task automatic rd(input logic [3:0] a, input logic [15:0] exp);
        bus_req = {1'b1, 1'b0, a, 2'b11, 16'h0000};
        tick(1);
        bus_req.rd = 0;
        chk(16'(bus_rvalid), 16'h0001);
        chk(bus_rdata, exp);
        tick(1);
    endtask

    // ----------------
    // Scenarios
    // ----------------
    initial begin
        tick(16);
        reset = 0;
        // Codes 5 to 7 are kept but are no trigger modes; ending on 0
        // leaves the internal clock selected for the next scenario
        for (int m = 7; m >= 0; m--) begin
            d = {8'h00, m[0], m[1], 1'b0, m[0], m[1], 3'(m)};
            wr(4'h6, 2'b01, d);
            chk(16'(acq_mode_field), 16'(m));
            chk(16'(trigger_mode_active), 16'(m >= 2 && m <= 4));
            chk(16'(calibration_routing_bit), 16'(m[0]));
            rd(4'h6, d & 16'h007f);
        end
        // Internal source: the pin is ignored, the tick passes; then external source: the reverse
        mark();
        internal_sample_tick = 1;
        ext_sample_clock_pin = 1;
        tick(1);
        internal_sample_tick = 0;
        tick(6);
        ext_sample_clock_pin = 0;
        chkc(0, 1);
        wr(4'h6, 2'b01, 16'h0008);
        mark();
        internal_sample_tick = 1;
        ext_sample_clock_pin = 1;
        tick(1);
        internal_sample_tick = 0;
        tick(6);
        ext_sample_clock_pin = 0;
        tick(6);
        chkc(0, 1);
        // Every source and edge; the unselected pin toggles first
        for (int k = 0; k < 4; k++) begin
            e = k[1];
            s = k[0];
            digital_trigger_pin = e;
            analog_trigger_pin = e;
            wr(4'h6, 2'b01, {8'h00, 1'b0, e, 1'b0, s, 4'h0});
            tick(6);
            wr(4'h6, 2'b10, 16'h0000);
            mark();
            if (s) digital_trigger_pin = !e; else analog_trigger_pin = !e;
            tick(6);
            chkc(1, 0);
            if (s) analog_trigger_pin = !e; else digital_trigger_pin = !e;
            tick(6);
            chkc(1, 1);
            digital_trigger_pin = e;
            analog_trigger_pin = e;
            tick(6);
            chkc(1, 1);
            rd(4'h6, {8'h80, 1'b0, e, 1'b0, s, 4'h0});
        end
        wr(4'h6, 2'b10, 16'h0000);
        mark();
        wr(4'h6, 2'b10, 16'hc000);
        rd(4'h6, 16'hc050);
        chkc(1, 1);
        chkc(2, 1);
        wr(4'h6, 2'b01, 16'h0050);
        rd(4'h6, 16'hc050);
        wr(4'h6, 2'b10, 16'h0000);
        rd(4'h6, 16'h0050);
        mark();
        dma_terminal_count = 1;
        tick(1);
        dma_terminal_count = 0;
        chkc(2, 1);
        rd(4'h6, 16'h4050);
        // Interrupt and FIFO status, then the clear strobes
        irq_pending = 1;
        in_fifo_flags = 3'b110;
        out_fifo_flags = 3'b011;
        rd(4'h8, 16'h6301);
        irq_pending = 0;
        in_fifo_flags = 3'b001;
        out_fifo_flags = 3'b100;
        rd(4'h8, 16'h1400);
        mark();
        wr(4'h8, 2'b01, 16'hffff);
        chkc(3, 1);
        wr(4'h8, 2'b10, 16'h8800);
        chkc(4, 0);
        wr(4'h8, 2'b10, 16'h8000);
        chkc(4, 1);
        chkc(5, 0);
        wr(4'h8, 2'b10, 16'h0800);
        chkc(5, 1);
        chkc(3, 1);
        // Unmapped place reads zero and changes nothing
        wr(4'ha, 2'b11, 16'hffff);
        rd(4'ha, 16'h0000);
        rd(4'h6, 16'h4050);
        sample_valid = 1;
        sample_data = 15'h1234;
        tick(1);
        sample_valid = 0;
        chk(16'(stored_valid), 16'h0001);
        chk(stored_word, 16'h1234);
        wr(4'h6, 2'b10, 16'h8000);
        sample_valid = 1;
        sample_data = 15'h5a5a;
        tick(1);
        sample_valid = 0;
        chk(stored_word, 16'hda5a);
        conclude();
    end
endmodule
`default_nettype wire
